// ===== logic/asq_top.sv
// Module: command interpreter of the delta-sigma converter serial port
//
// Behaviour
// - Enable input high enables conversions; host raises it before configuring.
// - Opcode 06h resets device; host waits 0.6 ms before next command.
// - Opcode 16h leaves continuous read so new data disturbs shifting only when it lands in the cycle the 12h opcode arrives.
// - 40h, 03h then four bytes writes the four configuration registers.
// - 20h, 03h returns four configuration bytes for read-back.
// - Opcode 04h starts a new conversion.
// - Chip select high resets serial interface, dropping partial commands.
// - Data-ready output falls when new conversion data is available.
// - After 12h, sixteen clocks shift the result out on serial output.
// - Opcode 02h stops conversions and enters power-down.
// - Data changes on rising clock edges, sampled on falling edges.
// - After reset continuous read is on; result clocks out after data-ready falls.
`timescale 1ns/1ps
`default_nettype none
module asq_top
  import asq_pkg::*;
#(
  parameter int CONV_CYC = ASQ_CONV_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 sclk_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 din_i,
  input  wire logic                 start_i,
  input  wire logic [ASQ_RES_W-1:0] sample_i,
  output logic                      serial_out_with_ready_o,
  output logic                      data_ready_n_o,
  output logic                      power_down_o,
  output logic                      continuous_read_mode_o,
  output logic [8*ASQ_NREG-1:0]     config_o
);
  import asq_pkg::*;
  typedef struct packed {
    asq_cmd_t             cmd;
    logic [1:0]           idx;
    logic [1:0]           left;
    logic [8*ASQ_NREG-1:0] cfg;
    logic                 crm;
    logic                 pd;
    logic                 conv_run;
    logic [31:0]          timer;
    logic [ASQ_RES_W-1:0] result;
    logic                 data_ready_n_n;
    logic [1:0]           out_left;
    logic [7:0]           tx;
    logic                 tx_load;
    logic                 in_frame_read;
    logic [1:0]           start_s;
  } asq_st_t;
  asq_st_t st, next_st;
  logic conv_latch;
  asq_bit_if bus ();
  logic dout_raw;
  asq_shifter u_shifter (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .sclk_i (sclk_i),
    .cs_n_i (cs_n_i),
    .din_i  (din_i),
    .dout_o (dout_raw),
    .bus    (bus.shifter)
  );
  function automatic logic [7:0] cfg_byte(input logic [8*ASQ_NREG-1:0] c,
                                          input logic [1:0] i);
    cfg_byte = c[8*i +: 8];
  endfunction
  always_comb begin
    next_st = st;
    next_st.start_s = {st.start_s[0], start_i};
    next_st.tx_load = 1'b0;
    // New result this cycle; it beats the data-ready clear when a read starts below
    conv_latch = st.start_s[1] && !st.pd && st.conv_run && (st.timer >= CONV_CYC - 1)
                 && !(st.in_frame_read && !st.crm);
    // Conversion pacing; enable pin gates it, sleep halts it
    if (st.start_s[1] && !st.pd && st.conv_run) begin
      if (st.timer >= CONV_CYC - 1) begin
        next_st.timer = '0;
        // Result held while a 12h frame reads it with continuous read off, so that shifting is not disturbed
        if (!(st.in_frame_read && !st.crm)) begin
          next_st.result = sample_i;
          next_st.data_ready_n_n = 1'b0;
        end
      end else begin
        next_st.timer = st.timer + 32'h1;
      end
    end
    // Continuous read: result goes out on the first two bytes after data-ready
    if (bus.byte_start && st.out_left == 2'h0 && st.crm && !st.data_ready_n_n
        && st.cmd == ASQ_IDLE) begin
      next_st.out_left = 2'h1;
      next_st.data_ready_n_n = !conv_latch;
    end
    if (bus.rx_valid) begin
      if (st.out_left == 2'h1) begin
        next_st.tx = st.result[7:0];
        next_st.tx_load = 1'b1;
        next_st.out_left = 2'h2;
      end else if (st.out_left == 2'h2) begin
        next_st.out_left = 2'h0;
        next_st.in_frame_read = 1'b0;
      end
      case (st.cmd)
        ASQ_IDLE: begin
          if (bus.rx_byte == ASQ_OP_RESET) begin
            next_st.cfg = {ASQ_REG3_RST, ASQ_REG2_RST, ASQ_REG1_RST, ASQ_REG0_RST};
            next_st.crm = 1'b1;
            next_st.pd = 1'b0;
            next_st.timer = '0;
            next_st.data_ready_n_n = 1'b1;
            next_st.conv_run = 1'b1;
          end else if (bus.rx_byte == ASQ_OP_STOPRC) begin
            next_st.crm = 1'b0;
          end else if (bus.rx_byte[7:4] == ASQ_OP_WRITE[7:4]) begin
            next_st.idx = bus.rx_byte[1:0];
            next_st.cmd = ASQ_WARG;
          end else if (bus.rx_byte[7:4] == ASQ_OP_READ[7:4]) begin
            next_st.idx = bus.rx_byte[1:0];
            next_st.cmd = ASQ_RARG;
          end else if (bus.rx_byte == ASQ_OP_START) begin
            next_st.timer = '0;
            next_st.pd = 1'b0;
            next_st.conv_run = 1'b1;
            next_st.data_ready_n_n = 1'b1;
          end else if (bus.rx_byte == ASQ_OP_RDATA) begin
            next_st.tx = st.result[15:8];
            next_st.tx_load = 1'b1;
            next_st.out_left = 2'h1;
            next_st.data_ready_n_n = !conv_latch;
            next_st.in_frame_read = 1'b1;
          end else if (bus.rx_byte == ASQ_OP_SLEEP) begin
            next_st.pd = 1'b1;
            next_st.conv_run = 1'b0;
          end
        end
        ASQ_WARG: begin
          next_st.left = bus.rx_byte[1:0] & ASQ_ADDR_MASK;
          next_st.cmd = ASQ_WDATA;
        end
        ASQ_WDATA: begin
          next_st.cfg[8*st.idx +: 8] = bus.rx_byte;
          next_st.idx = st.idx + 2'h1;
          next_st.left = st.left - 2'h1;
          if (st.left == 2'h0) begin
            next_st.cmd = ASQ_IDLE;
          end
        end
        ASQ_RARG: begin
          next_st.left = bus.rx_byte[1:0] & ASQ_ADDR_MASK;
          next_st.tx = cfg_byte(st.cfg, st.idx);
          next_st.tx_load = 1'b1;
          next_st.idx = st.idx + 2'h1;
          next_st.cmd = ASQ_RDATA_ST;
        end
        ASQ_RDATA_ST: begin
          if (st.left == 2'h0) begin
            next_st.cmd = ASQ_IDLE;
          end else begin
            next_st.tx = cfg_byte(st.cfg, st.idx);
            next_st.tx_load = 1'b1;
            next_st.idx = st.idx + 2'h1;
            next_st.left = st.left - 2'h1;
          end
        end
        default: next_st.cmd = ASQ_IDLE;
      endcase
    end
    if (bus.frame_rst) begin
      next_st.cmd = ASQ_IDLE;
      next_st.out_left = 2'h0;
      next_st.in_frame_read = 1'b0;
      // Preload while deselected: the first rise already needs the MSB
      if (st.crm && !st.data_ready_n_n) begin
        next_st.tx = st.result[15:8];
        next_st.tx_load = 1'b1;
      end
    end
    if (rst_i) begin
      next_st = '0;
      next_st.cfg = {ASQ_REG3_RST, ASQ_REG2_RST, ASQ_REG1_RST, ASQ_REG0_RST};
      next_st.crm = 1'b1;
      next_st.data_ready_n_n = 1'b1;
      next_st.conv_run = 1'b1;
      next_st.cmd = ASQ_IDLE;
    end
  end
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end
  assign bus.tx_load = st.tx_load;
  assign bus.tx_byte = st.tx;
  // Pin carries ready state while deselected; select is the synchronised one
  assign serial_out_with_ready_o = bus.frame_rst ? st.data_ready_n_n : dout_raw;
  assign data_ready_n_o = st.data_ready_n_n;
  assign power_down_o = st.pd;
  assign continuous_read_mode_o = st.crm;
  assign config_o = st.cfg;
endmodule
`default_nettype wire

// ===== logic/asq_pkg.sv
// Package: opcodes, config layout and timing for the ADC serial command block
package asq_pkg;
  localparam logic [7:0] ASQ_OP_RESET  = 8'h06;
  localparam logic [7:0] ASQ_OP_STOPRC = 8'h16;
  localparam logic [7:0] ASQ_OP_WRITE  = 8'h40;
  localparam logic [7:0] ASQ_OP_READ   = 8'h20;
  localparam logic [7:0] ASQ_OP_START  = 8'h04;
  localparam logic [7:0] ASQ_OP_RDATA  = 8'h12;
  localparam logic [7:0] ASQ_OP_SLEEP  = 8'h02;
  localparam logic [7:0] ASQ_OP_NOP    = 8'hFF;
  localparam int         ASQ_NREG      = 4;
  localparam int         ASQ_RES_W     = 16;
  localparam logic [7:0] ASQ_REG0_RST  = 8'h01;
  localparam logic [7:0] ASQ_REG1_RST  = 8'h00;
  localparam logic [7:0] ASQ_REG2_RST  = 8'h00;
  localparam logic [7:0] ASQ_REG3_RST  = 8'h00;
  localparam logic [1:0] ASQ_ADDR_MASK = 2'h3;
  localparam int         ASQ_CLK_HZ    = 25000000;
  localparam int         ASQ_CONV_US   = 1000;
  localparam int         ASQ_CONV_CYC  = (ASQ_CLK_HZ / 1000000) * ASQ_CONV_US;
  localparam logic [2:0] ASQ_BIT_LAST  = 3'h7;
  typedef enum logic [2:0] {ASQ_IDLE, ASQ_WARG, ASQ_WDATA, ASQ_RARG, ASQ_RDATA_ST}
    asq_cmd_t;
endpackage

// ===== logic/asq_bit_if.sv
// Interface: byte stream between serial shifter and command decoder
`timescale 1ns/1ps
`default_nettype none
interface asq_bit_if;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       frame_rst;
  logic       tx_load;
  logic [7:0] tx_byte;
  logic       byte_start;
  modport shifter (output rx_valid, output rx_byte, output frame_rst, output byte_start,
                   input tx_load, input tx_byte);
  modport decoder (input rx_valid, input rx_byte, input frame_rst, input byte_start,
                   output tx_load, output tx_byte);
endinterface
`default_nettype wire

// ===== logic/asq_shifter.sv
// Module: SPI mode 1 byte shifter sampling the serial clock in the system domain
`timescale 1ns/1ps
`default_nettype none
module asq_shifter
  import asq_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   sclk_i,
  input  wire logic   cs_n_i,
  input  wire logic   din_i,
  output logic        dout_o,
  asq_bit_if.shifter  bus
);
  import asq_pkg::*;
  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] din_s;
    logic       sclk_d;
    logic [2:0] cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic       dout;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       frame_rst;
  } asq_sh_t;
  asq_sh_t st, next_st;
  logic rise, fall;
  always_comb begin
    next_st = st;
    next_st.sclk_s = {st.sclk_s[0], sclk_i};
    next_st.cs_s = {st.cs_s[0], cs_n_i};
    next_st.din_s = {st.din_s[0], din_i};
    next_st.sclk_d = st.sclk_s[1];
    next_st.rx_valid = 1'b0;
    next_st.frame_rst = 1'b0;
    rise = st.sclk_s[1] && !st.sclk_d;
    fall = !st.sclk_s[1] && st.sclk_d;
    if (bus.tx_load) begin
      next_st.tx = bus.tx_byte;
    end
    if (st.cs_s[1]) begin
      next_st.cnt = 3'h0;
      next_st.frame_rst = 1'b1;
    end else if (rise) begin
      next_st.dout = next_st.tx[7];
      next_st.tx = {next_st.tx[6:0], 1'b0};
    end else if (fall) begin
      next_st.rx = {st.rx[6:0], st.din_s[1]};
      next_st.cnt = st.cnt + 3'h1;
      if (st.cnt == ASQ_BIT_LAST) begin
        next_st.rx_valid = 1'b1;
        next_st.rx_byte = {st.rx[6:0], st.din_s[1]};
      end
    end
    if (rst_i) begin
      next_st = '0;
      next_st.cs_s = 2'h3;
      // Deselected from reset on, so the pin shows ready state at once
      next_st.frame_rst = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end
  assign bus.rx_valid = st.rx_valid;
  assign bus.rx_byte = st.rx_byte;
  assign bus.frame_rst = st.frame_rst;
  assign bus.byte_start = rise && (st.cnt == 3'h0) && !st.cs_s[1];
  assign dout_o = st.dout;
endmodule
`default_nettype wire

// ===== dv/asq_properties.sv
// Checker: port properties of the converter command block
`timescale 1ns/1ps
`default_nettype none
module asq_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        sclk_i,
  input wire logic        cs_n_i,
  input wire logic        serial_out_with_ready_o,
  input wire logic        data_ready_n_o,
  input wire logic        power_down_o,
  input wire logic        continuous_read_mode_o,
  input wire logic [31:0] config_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // **********
  // Properties
  // **********
  chk_idle_ready: assert property (cs_n_i [*6] |->
    serial_out_with_ready_o == data_ready_n_o) else $error("idle out not ready");
  chk_reset_vals: assert property ($fell(rst_i) |-> data_ready_n_o &&
    continuous_read_mode_o && !power_down_o && config_o == 32'h00000001)
    else $error("bad reset state");
  chk_sleep_quiet: assert property (power_down_o [*3] |-> !$fell(data_ready_n_o))
    else $error("result while asleep");
  // Synchroniser puts output moves two to four clocks after the rise
  chk_out_on_rise: assert property ((!cs_n_i) [*8] ##0 $changed(serial_out_with_ready_o)
    |-> $past(sclk_i, 2) || $past(sclk_i, 3) || $past(sclk_i, 4)) else $error("out off rise");
  chk_cfg_frame: assert property ($changed(config_o) |-> $past(rst_i) || !$past(cs_n_i, 2))
    else $error("config outside frame");
  chk_crm_frame: assert property ($changed(continuous_read_mode_o) |->
    $past(rst_i) || !$past(cs_n_i, 2)) else $error("mode outside frame");
  chk_pd_frame: assert property ($rose(power_down_o) |-> !$past(cs_n_i, 2))
    else $error("sleep outside frame");
  chk_ready_clear: assert property ($rose(data_ready_n_o) |->
    $past(rst_i) || !$past(cs_n_i, 2)) else $error("ready cleared outside frame");
  cov_ready: cover property ($fell(data_ready_n_o));
  cov_stop: cover property ($fell(continuous_read_mode_o));
  cov_sleep: cover property ($rose(power_down_o));
endmodule
bind asq_top asq_properties chk (.clk_i, .rst_i, .sclk_i, .cs_n_i, .serial_out_with_ready_o,
  .data_ready_n_o, .power_down_o, .continuous_read_mode_o, .config_o);
`default_nettype wire

// ===== dv/asq_host.sv
// Partner: host master on the serial port, mode 1
`timescale 1ns/1ps
`default_nettype none
module asq_host (
  input  wire logic  clk_i,
  input  wire logic  dout_i,
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic       din_o,
  output logic       rx_stb_o,
  output logic [7:0] rx_o
);
  logic busy;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    rx_stb_o = 1'b0;
    rx_o = 8'h00;
    busy = 1'b0;
  end
  // **********
  // Transfers
  // **********
  // Released data line toggles so a stale bit never looks driven
  always @(posedge clk_i) begin
    if (!busy) din_o <= ~din_o;
  end
  task automatic open_f();
    @(posedge clk_i);
    busy <= 1'b1;
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic close_f();
    repeat (8) @(posedge clk_i);
    cs_n_o <= 1'b1;
    busy <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic xfer(input logic [7:0] tx, input bit chk);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_i);
      sclk_o <= 1'b1;
      din_o <= tx[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      // Read late in the low phase; output holds until the next rise
      repeat (3) @(posedge clk_i);
      rx[i] = dout_i;
    end
    rx_o <= rx;
    rx_stb_o <= chk;
    @(posedge clk_i);
    rx_stb_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/asq_top_tb.sv
// Testbench: command sequence of the converter block
`timescale 1ns/1ps
`default_nettype none
module asq_top_tb;
  import asq_pkg::*;
  localparam int CONV = 600;
  logic        clk_i, rst_i, start_i, sclk, cs_n, din, dout, stb, data_ready_n_n, pd, crm;
  logic [15:0] sample;
  logic [7:0]  rx;
  logic [31:0] cfg;
  logic [7:0]  exp_q[$];
  logic [7:0]  wr[6] = '{8'h40, 8'h03, 8'h01, 8'h00, 8'h03, 8'h42};
  int          n_mismatch, samples_checked, seed;
  asq_top #(.CONV_CYC(CONV)) dut (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .start_i(start_i), .sample_i(sample), .serial_out_with_ready_o(dout),
    .data_ready_n_o(data_ready_n_n), .power_down_o(pd), .continuous_read_mode_o(crm), .config_o(cfg));
  asq_host host (.clk_i(clk_i), .dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .rx_stb_o(stb), .rx_o(rx));
  // **********
  // Helpers
  // **********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tx(input logic [7:0] b, input bit c, input logic [7:0] e);
    if (c) exp_q.push_back(e);
    host.xfer(b, c);
  endtask
  task automatic cmd(input logic [7:0] b);
    host.open_f();
    tx(b, 0, 8'h00);
    host.close_f();
  endtask
  task automatic wait_rdy();
    for (int k = 0; k < 3000 && data_ready_n_n !== 1'b0; k++) @(posedge clk_i);
    chk({31'h0, data_ready_n_n}, 32'h00000000);
  endtask
  task automatic rdata();
    host.open_f();
    tx(ASQ_OP_RDATA, 0, 8'h00);
    tx(ASQ_OP_NOP, 1, sample[15:8]);
    tx(ASQ_OP_NOP, 1, sample[7:0]);
    host.close_f();
  endtask
  task automatic wrap_up();
    chk(32'(exp_q.size()), 32'h00000000);
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (stb === 1'b1) chk({24'h0, rx}, {24'h0, exp_q.pop_front()});
  end
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Limit is a few times the planned run
  initial begin
    #2000000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    seed = 2581;
    n_mismatch = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    start_i = 1'b0;
    sample = 16'h0000;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    sample <= 16'($random(seed));
    // Short settle; no supply ramp in this model
    repeat (4) @(posedge clk_i);
    chk({29'h0, crm, pd, data_ready_n_n}, 32'h00000005);
    chk(cfg, 32'h00000001);
    start_i <= 1'b1;
    wait_rdy();
    host.open_f();
    tx(ASQ_OP_NOP, 1, sample[15:8]);
    tx(ASQ_OP_NOP, 1, sample[7:0]);
    host.close_f();
    $display("test continuous read done");
    cmd(ASQ_OP_RESET);
    repeat (15000) @(posedge clk_i);
    chk({31'h0, crm}, 32'h00000001);
    cmd(ASQ_OP_STOPRC);
    chk({31'h0, crm}, 32'h00000000);
    // Dropped opcode must not turn the next write's opcode into a count
    cmd(ASQ_OP_WRITE);
    host.open_f();
    for (int k = 0; k < 6; k++) tx(wr[k], 0, 8'h00);
    host.close_f();
    chk(cfg, 32'h42030001);
    host.open_f();
    tx(ASQ_OP_READ, 0, 8'h00);
    tx(8'h03, 0, 8'h00);
    for (int k = 2; k < 6; k++) tx(ASQ_OP_NOP, 1, wr[k]);
    host.close_f();
    $display("test registers done");
    sample <= 16'($random(seed));
    cmd(ASQ_OP_START);
    wait_rdy();
    rdata();
    chk({31'h0, data_ready_n_n}, 32'h00000001);
    // Poll without data-ready: one full period guarantees a fresh result
    sample <= 16'($random(seed));
    repeat (CONV + 20) @(posedge clk_i);
    rdata();
    $display("test read data done");
    // Restart the pacing so no result lands before sleep is taken
    cmd(ASQ_OP_START);
    cmd(ASQ_OP_SLEEP);
    repeat (2 * CONV) @(posedge clk_i);
    chk({30'h0, pd, data_ready_n_n}, 32'h00000003);
    $display("test sleep done");
    wrap_up();
  end
endmodule
`default_nettype wire
